//--- lbcc_pkg.sv
// Purpose: Shared types and constants for the local bus cycle controller
// Assumes: One double-rate clock; all inputs synchronous to it
// Notes:   State codes are fixed by the external decoder that reads them
package lbcc_pkg;

    // Clock period of the double-rate clock in ns
    localparam int LBCC_CLK_PERIOD_NS = 100;

    // Bus tracker codes, read as {overlapFirst, quiet}
    typedef enum logic [1:0] {
        BUS_BUSY    = 2'b00,
        BUS_QUIET   = 2'b01,
        BUS_OVERLAP = 2'b10,
        BUS_INVALID = 2'b11
    } lbcc_bus_e;

    // Local sequencer codes
    typedef enum logic [2:0] {
        LS_PAUSE    = 3'b000,
        LS_FOREIGN  = 3'b001,
        LS_PCMD_ON  = 3'b010,
        LS_ONE_WAIT = 3'b011,
        LS_SAMPLE   = 3'b100,
        LS_AWAIT    = 3'b101,
        LS_PCMD_OFF = 3'b110,
        LS_RELEASE  = 3'b111
    } lbcc_local_e;

    // Delay counter steps, delay_nonzero down 3-2-1-0
    typedef enum logic [1:0] {
        DLY_0 = 2'b00,
        DLY_1 = 2'b01,
        DLY_2 = 2'b11,
        DLY_3 = 2'b10
    } lbcc_delay_e;

    // Cycle definition inputs from the processor
    typedef struct packed {
        logic memOrPortN;
        logic dataOrCodeN;
        logic writeNotRead;
    } lbcc_cycdef_s;

    // Active-low device selects
    typedef struct packed {
        logic selZeroWaitN;
        logic selOneWaitN;
        logic selPeripheralN;
    } lbcc_sel_s;

    // Five active-low command strobes
    typedef struct packed {
        logic memRdN;
        logic memWrN;
        logic ioRdN;
        logic ioWrN;
        logic intAckN;
    } lbcc_cmd_s;

    // Every flip-flop of the controller
    typedef struct packed {
        lbcc_bus_e busTrk;
        lbcc_local_e lseq;
        lbcc_delay_e dly;
        logic naActive;
        lbcc_cmd_s cmd;
        logic readyOutN;
        logic latchEn;
        logic xcvrEnN;
        logic xcvrDir;
    } lbcc_state_s;

    // All strobes idle
    localparam lbcc_cmd_s LBCC_CMD_IDLE = 5'h1F;

    // Reset image of the whole state
    localparam lbcc_state_s LBCC_STATE_RESET = '{
        busTrk: BUS_QUIET, lseq: LS_AWAIT, dly: DLY_0,
        naActive: 1'b0, cmd: LBCC_CMD_IDLE, readyOutN: 1'b1,
        latchEn: 1'b0, xcvrEnN: 1'b1, xcvrDir: 1'b0};

endpackage

//--- lbcc_ctrl.sv
// Purpose: Local bus cycle controller: bus tracker, local sequencer,
//          delay counter, next-address request and command generator
// Assumes: Inputs are synchronous to clk; processor clock is a phase input
// Notes:   Command outputs are registered, aligned with the state bits
`timescale 1ns/1ps
`default_nettype none

module lbcc_ctrl
    import lbcc_pkg::*;
(
    // Clock, reset, enable
    input wire logic clk,
    input wire logic srst,
    input wire logic clkEn,
    // Processor bus
    input wire logic procClkPhase,
    input wire logic addrStrobeN,
    input wire logic cycleDoneInN,
    input wire lbcc_cycdef_s cycDef,
    // Device selects
    input wire lbcc_sel_s sel,
    // Tracker and sequencer state
    output logic busQuiet,
    output logic busOverlapFirst,
    output logic [2:0] localStateBits,
    output logic [1:0] delayCountBits,
    // Pipelining request
    output logic nextAddrReqN,
    // Commands and data path control
    output lbcc_cmd_s cmd,
    output logic cycleDoneOutN,
    output logic addrLatchEn,
    output logic xcvrEnableN,
    output logic xcvrDirection
);

    // Registered state and its next value
    lbcc_state_s state_q;
    lbcc_state_s state_d;

    // Delay counter not yet at zero
    function automatic logic delayNonzero(input lbcc_delay_e v);
        delayNonzero = v[1] | v[0];
    endfunction

    // Low bit alone, valid for counts under three
    function automatic logic delayLowBit(input lbcc_delay_e v);
        delayLowBit = v[0];
    endfunction

    // One step down the count
    function automatic lbcc_delay_e delayStep(input lbcc_delay_e v);
        case (v)
            DLY_3: delayStep = DLY_2;
            DLY_2: delayStep = DLY_1;
            DLY_1: delayStep = DLY_0;
            default: delayStep = DLY_0;
        endcase
    endfunction

    // Start value picked by the local state at zero
    function automatic lbcc_delay_e delayLoad(
        input lbcc_local_e ls,
        input logic oneWaitN,
        input logic wr,
        input logic na
    );
        case (ls)
            // One-wait access needs two steps
            LS_SAMPLE: delayLoad = oneWaitN ? DLY_0 : DLY_2;
            // Write holds the command longer
            LS_PAUSE: delayLoad = wr ? DLY_3 : DLY_2;
            // Command end once request is up
            LS_PCMD_ON: delayLoad = na ? DLY_1 : DLY_0;
            // Float after peripheral command
            LS_PCMD_OFF: delayLoad = DLY_3;
            // Float after one-wait command
            LS_ONE_WAIT: delayLoad = DLY_1;
            // Peripheral recovery
            LS_RELEASE: delayLoad = DLY_1;
            default: delayLoad = DLY_0;
        endcase
    endfunction

    // Strobe decode from the cycle definition
    function automatic lbcc_cmd_s cmdDecode(
        input lbcc_cycdef_s c,
        input logic act
    );
        cmdDecode = LBCC_CMD_IDLE;
        if (act) begin
            // Memory data or code cycle
            if (c.memOrPortN) begin
                cmdDecode.memRdN = c.writeNotRead;
                cmdDecode.memWrN = ~c.writeNotRead;
            end else if (c.dataOrCodeN) begin
                // Port cycle
                cmdDecode.ioRdN = c.writeNotRead;
                cmdDecode.ioWrN = ~c.writeNotRead;
            end else if (!c.writeNotRead) begin
                // Interrupt acknowledge
                cmdDecode.intAckN = 1'b0;
            end
        end
    endfunction

    // Next-state logic for every machine
    always_comb begin
        logic phase;
        logic quiet;
        logic zwSel;
        logic cmdAct;
        phase = procClkPhase;
        quiet = (state_q.busTrk == BUS_QUIET);
        zwSel = ~sel.selZeroWaitN;
        cmdAct = 1'b0;
        state_d = state_q;
        // Everything holds while the enable is low
        if (clkEn) begin
            // Bus tracker
            case (state_q.busTrk)
                BUS_QUIET: begin
                    // Strobe seen at phase high
                    if (phase && !addrStrobeN) begin
                        state_d.busTrk = BUS_BUSY;
                    end
                end
                BUS_BUSY: begin
                    // Done seen; pipelined or idle next
                    if (phase && !cycleDoneInN) begin
                        state_d.busTrk = addrStrobeN ?
                            BUS_QUIET : BUS_OVERLAP;
                    end
                end
                BUS_OVERLAP: begin
                    // One processor clock only
                    if (phase) begin
                        state_d.busTrk = BUS_BUSY;
                    end
                end
                default: begin
                    // Unused code recovers at once
                    state_d.busTrk = BUS_QUIET;
                end
            endcase

            // Request off unless a state drives it
            state_d.naActive = 1'b0;

            // Local sequencer
            case (state_q.lseq)
                LS_AWAIT: begin
                    // Hold on low phase, idle bus or recovery
                    if (!(!phase || (addrStrobeN && quiet) ||
                          (!sel.selPeripheralN &&
                           delayLowBit(state_q.dly)))) begin
                        state_d.lseq = LS_SAMPLE;
                    end
                end
                LS_SAMPLE: begin
                    // Route by select
                    if (!sel.selOneWaitN) begin
                        state_d.lseq = LS_ONE_WAIT;
                    end else if (!sel.selPeripheralN) begin
                        state_d.lseq = LS_PAUSE;
                    end else begin
                        state_d.lseq = LS_FOREIGN;
                    end
                end
                LS_PAUSE: begin
                    // Single clock before the command
                    state_d.lseq = LS_PCMD_ON;
                end
                LS_PCMD_ON: begin
                    // Raise at zero count, then keep
                    state_d.naActive = (!delayNonzero(state_q.dly) &&
                        phase) || state_q.naActive;
                    if (state_q.naActive) begin
                        state_d.lseq = LS_PCMD_OFF;
                    end
                end
                LS_PCMD_OFF: begin
                    // Wait out the count
                    if (!delayLowBit(state_q.dly)) begin
                        state_d.lseq = LS_RELEASE;
                    end
                end
                LS_ONE_WAIT: begin
                    // Toggles at each clock with phase high
                    state_d.naActive = state_q.naActive ^ phase;
                    if (!delayLowBit(state_q.dly)) begin
                        state_d.lseq = LS_RELEASE;
                    end
                end
                LS_RELEASE: begin
                    // A non-local cycle starting during float
                    if (!quiet && !phase && (&sel)) begin
                        state_d.lseq = LS_FOREIGN;
                    end else if (!delayNonzero(state_q.dly)) begin
                        state_d.lseq = LS_AWAIT;
                    end
                end
                LS_FOREIGN: begin
                    // Wait for the cycle to finish
                    if (phase && !cycleDoneInN) begin
                        if (delayNonzero(state_q.dly)) begin
                            state_d.lseq = LS_RELEASE;
                        end else if (!addrStrobeN) begin
                            state_d.lseq = LS_SAMPLE;
                        end else begin
                            state_d.lseq = LS_AWAIT;
                        end
                    end
                end
                default: begin
                    state_d.lseq = LS_AWAIT;
                end
            endcase

            // Delay counter: step or reload
            if (delayNonzero(state_q.dly)) begin
                if (phase) begin
                    state_d.dly = delayStep(state_q.dly);
                end
            end else begin
                state_d.dly = delayLoad(state_q.lseq,
                    sel.selOneWaitN, cycDef.writeNotRead,
                    state_q.naActive);
            end

            // Command generator on the new local state
            case (state_d.lseq)
                LS_PCMD_ON, LS_ONE_WAIT: cmdAct = 1'b1;
                LS_FOREIGN: cmdAct = zwSel;
                default: cmdAct = 1'b0;
            endcase
            state_d.cmd = cmdDecode(cycDef, cmdAct);
            // Done at end of each local command
            state_d.readyOutN = ~(
                ((state_d.lseq == LS_PCMD_OFF) &&
                 (state_q.lseq == LS_PCMD_ON)) ||
                ((state_d.lseq == LS_RELEASE) &&
                 (state_q.lseq == LS_ONE_WAIT)) ||
                ((state_d.lseq == LS_FOREIGN) && zwSel &&
                 phase));
            // Address latch open while selects settle
            state_d.latchEn = (state_d.lseq == LS_SAMPLE);
            // Transceiver on for any local data phase
            state_d.xcvrEnN = ~(cmdAct ||
                (state_d.lseq == LS_PCMD_OFF));
            // Direction only follows while transceiver is off
            if (state_q.xcvrEnN) begin
                state_d.xcvrDir = cycDef.writeNotRead;
            end
        end
    end

    // Single register for all state, double-rate clock
    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= LBCC_STATE_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // Outputs straight from the register
    assign busOverlapFirst = state_q.busTrk[1];
    assign busQuiet = state_q.busTrk[0];
    assign localStateBits = state_q.lseq;
    assign delayCountBits = state_q.dly;
    assign nextAddrReqN = ~state_q.naActive;
    assign cmd = state_q.cmd;
    assign cycleDoneOutN = state_q.readyOutN;
    assign addrLatchEn = state_q.latchEn;
    assign xcvrEnableN = state_q.xcvrEnN;
    assign xcvrDirection = state_q.xcvrDir;

    // Checks on the controller's own behaviour
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    a_trk_quiet_exit: assert property (
        clkEn && busQuiet && !busOverlapFirst && procClkPhase &&
        !addrStrobeN |=> !busQuiet && !busOverlapFirst)
        else $error("tracker did not leave quiet");

    a_trk_done_pipe: assert property (
        clkEn && state_q.busTrk == BUS_BUSY && procClkPhase &&
        !cycleDoneInN && !addrStrobeN |=> busOverlapFirst && !busQuiet)
        else $error("tracker missed overlap");

    a_trk_overlap_once: assert property (
        clkEn && state_q.busTrk == BUS_OVERLAP && procClkPhase
        |=> state_q.busTrk == BUS_BUSY)
        else $error("overlap outlasted one clock");

    a_trk_invalid_back: assert property (
        clkEn && state_q.busTrk == BUS_INVALID
        |=> state_q.busTrk == BUS_QUIET)
        else $error("invalid tracker code stuck");

    a_seq_pause_once: assert property (
        clkEn && localStateBits == 3'h0 |=> localStateBits == 3'h2)
        else $error("pause not exactly one clock");

    a_seq_one_wait: assert property (
        clkEn && localStateBits == 3'h4 && !sel.selOneWaitN
        |=> localStateBits == 3'h3)
        else $error("one-wait select not taken");

    a_await_na_off: assert property (
        clkEn && state_q.lseq == LS_AWAIT |=> nextAddrReqN)
        else $error("request active after await");

    a_na_where_owned: assert property (
        !nextAddrReqN |-> state_q.lseq inside
        {LS_PCMD_OFF, LS_PCMD_ON, LS_ONE_WAIT, LS_RELEASE})
        else $error("request outside owned cycles");

    a_cmd_off_exit: assert property (
        clkEn && state_q.lseq == LS_PCMD_OFF && !delayCountBits[0]
        |=> state_q.lseq == LS_RELEASE)
        else $error("command off did not release");

    a_delay_step: assert property (
        clkEn && procClkPhase && state_q.dly == DLY_2
        |=> state_q.dly == DLY_1)
        else $error("delay counter skipped a step");

    a_dir_stable: assert property (
        !xcvrEnableN && $past(!xcvrEnableN)
        |-> xcvrDirection == $past(xcvrDirection))
        else $error("direction moved while enabled");

endmodule // lbcc_ctrl

`default_nettype wire

//--- lbcc_bus_model.sv
// Purpose: Processor side model: phase, address strobe and cycle done
// Assumes: Moves at falling clk edges; device done arrives on doneOutN
// Notes:   Holding req through a cycle makes the next one overlap
`timescale 1ns/1ps
`default_nettype none

module lbcc_bus_model
    import lbcc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic srst,
    // Test control
    input wire logic req,
    input wire logic [3:0] extWait,
    output logic busy,
    // Processor bus
    input wire logic cycleDoneOutN,
    output logic procClkPhase,
    output logic addrStrobeN,
    output logic cycleDoneInN
);
    logic [1:0] stbLeft; // Strobe edges still to run
    logic [3:0] waitCnt; // Phase-high edges since strobe
    logic devDone; // Device reported its own done
    logic endNow; // Cycle ends at this edge

    // Done once the device answers (now or earlier) or the wait runs out;
    // a device done seen now must reach the very next phase-high edge
    assign endNow = !procClkPhase && busy && stbLeft == 2'h0 &&
        (devDone || !cycleDoneOutN ||
         (extWait != 4'h0 && waitCnt >= extWait));

    // Strobe and done are active low; all bus lines move at falling edges
    always @(negedge clk) begin
        if (srst) begin
            procClkPhase <= 1'b0;
            addrStrobeN <= 1'b1;
            cycleDoneInN <= 1'b1;
            busy <= 1'b0;
            stbLeft <= 2'h0;
            waitCnt <= 4'h0;
            devDone <= 1'b0;
        end else begin
            procClkPhase <= ~procClkPhase;
            // Strobe low for one processor clock
            addrStrobeN <= (stbLeft != 2'h2);
            if (stbLeft != 2'h0) stbLeft <= stbLeft - 2'h1;
            if (procClkPhase) waitCnt <= waitCnt + 4'h1;
            if (!cycleDoneOutN) devDone <= 1'b1;
            // Done low across one phase-high edge only
            cycleDoneInN <= !endNow;
            if (endNow) busy <= req;
            if (endNow) devDone <= 1'b0;
            // New strobe from idle or overlapping the done edge
            if (!procClkPhase && req && (endNow || !busy)) begin
                addrStrobeN <= 1'b0;
                stbLeft <= 2'h2;
                waitCnt <= 4'h0;
                busy <= 1'b1;
                devDone <= 1'b0;
            end
        end
    end
endmodule // lbcc_bus_model

`default_nettype wire

//--- lbcc_ctrl_test.sv
// Purpose: Self-checking bench for the local bus cycle controller
// Assumes: 10 MHz clock; inputs change at falling edges
// Notes:   State traces are compressed, with a dwell count per entry
`timescale 1ns/1ps
`default_nettype none

module lbcc_ctrl_test
    import lbcc_pkg::*;
;
    // Stimulus
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic clkEn = 1'b1;
    logic req = 1'b0;
    logic [3:0] extWait = 4'h0;
    lbcc_cycdef_s cycDef = 3'h4;
    lbcc_sel_s sel = 3'h7;
    // Bus and outputs
    logic procClkPhase, addrStrobeN, cycleDoneInN, mBusy;
    logic busQuiet, busOverlapFirst, nextAddrReqN, cycleDoneOutN;
    logic addrLatchEn, xcvrEnableN, xcvrDirection;
    logic [2:0] localStateBits;
    logic [1:0] delayCountBits, prevDly, onDly;
    lbcc_cmd_s cmd, cmdOn;
    // Bookkeeping
    int nErrors = 0;
    int cmpCount = 0;
    int nStb = 0;
    int seqQ[$], seqDw[$], trkQ[$], trkDw[$];
    logic phSeen, enSeen, prevStbN, prevEnN, prevDir;
    logic rstSeen = 1'b1;
    logic naSeen, doneSeen, cmdSeen, dirOn;

    // Clock at 10 MHz
    always #(LBCC_CLK_PERIOD_NS / 2) clk = ~clk;

    lbcc_ctrl dut_u (
        .clk(clk), .srst(srst), .clkEn(clkEn), .procClkPhase(procClkPhase),
        .addrStrobeN(addrStrobeN), .cycleDoneInN(cycleDoneInN),
        .cycDef(cycDef), .sel(sel), .busQuiet(busQuiet),
        .busOverlapFirst(busOverlapFirst), .localStateBits(localStateBits),
        .delayCountBits(delayCountBits), .nextAddrReqN(nextAddrReqN),
        .cmd(cmd), .cycleDoneOutN(cycleDoneOutN), .addrLatchEn(addrLatchEn),
        .xcvrEnableN(xcvrEnableN), .xcvrDirection(xcvrDirection));

    lbcc_bus_model bus_u (
        .clk(clk), .srst(srst), .req(req), .extWait(extWait), .busy(mBusy),
        .cycleDoneOutN(cycleDoneOutN), .procClkPhase(procClkPhase),
        .addrStrobeN(addrStrobeN), .cycleDoneInN(cycleDoneInN));

    // One comparison, reported at once on mismatch
    task automatic chk(input logic ok, input string msg);
        cmpCount++;
        if (ok !== 1'b1) begin
            nErrors++;
            $display("[FAIL] %0t ns: %s", $time, msg);
        end
    endtask

    // Compare a compressed trace with the expected path
    task automatic chk_seq(input int got[$], input int e[$], input string m);
        logic ok;
        ok = (got.size() == e.size());
        foreach (e[k])
            if (ok && got[k] != e[k]) ok = 1'b0;
        chk(ok, m);
    endtask

    // Next step of the down counter
    function automatic logic [1:0] step(input logic [1:0] d);
        return (d == DLY_3) ? DLY_2 : ((d == DLY_2) ? DLY_1 : DLY_0);
    endfunction

    // Edge-time view of phase, reset and enable
    always @(posedge clk) begin
        phSeen <= procClkPhase;
        rstSeen <= srst;
        enSeen <= clkEn;
    end

    // Trace recorder and running checks on settled outputs
    always @(negedge clk) begin
        if (!rstSeen) begin
            if (seqQ.size() == 0 || seqQ[$] != localStateBits) begin
                seqQ.push_back(localStateBits);
                seqDw.push_back(1);
                if (localStateBits == LS_PCMD_ON) onDly = delayCountBits;
            end else seqDw[$] += 1;
            if (trkQ.size() == 0 || trkQ[$] != {busOverlapFirst, busQuiet})
            begin
                trkQ.push_back({busOverlapFirst, busQuiet});
                trkDw.push_back(1);
            end else trkDw[$] += 1;
            if (enSeen && prevDly != DLY_0 && delayCountBits != prevDly) begin
                chk(phSeen, "count moved at phase low");
                chk(delayCountBits == step(prevDly), "count order");
            end
            if (!prevEnN && !xcvrEnableN)
                chk(xcvrDirection === prevDir, "direction moved");
            chk(addrLatchEn === (localStateBits == LS_SAMPLE), "latch");
            chk(xcvrEnableN === !((localStateBits inside {LS_PCMD_ON,
                LS_PCMD_OFF, LS_ONE_WAIT}) || (localStateBits == LS_FOREIGN
                && !sel.selZeroWaitN)), "transceiver");
            if (!nextAddrReqN) naSeen = 1'b1;
            if (!cycleDoneOutN) doneSeen = 1'b1;
            if (cmd != LBCC_CMD_IDLE && !cmdSeen) cmdOn = cmd;
            if (cmd != LBCC_CMD_IDLE) cmdSeen = 1'b1;
            if (!xcvrEnableN) dirOn = xcvrDirection;
            if (!addrStrobeN && prevStbN) nStb++;
        end
        prevDly = delayCountBits;
        prevEnN = xcvrEnableN;
        prevDir = xcvrDirection;
        prevStbN = addrStrobeN;
    end

    // Hold reset, then check every output's reset value
    task automatic reset_check(input int n);
        srst <= 1'b1;
        req <= 1'b0;
        repeat (n) @(negedge clk);
        chk({busOverlapFirst, busQuiet} === BUS_QUIET, "tracker");
        chk(localStateBits === LS_AWAIT, "sequencer");
        chk(delayCountBits === DLY_0, "counter");
        chk({nextAddrReqN, cmd, cycleDoneOutN, addrLatchEn, xcvrEnableN,
            xcvrDirection} === 10'h3fa, "outputs");
        srst <= 1'b0;
        @(negedge clk);
        $display("reset test done");
    endtask

    // Run n strobes through the model and wait for the local side
    task automatic run_cycle(input lbcc_sel_s s, input logic wr,
        input logic [3:0] ew, input int n, input logic flip);
        int i;
        int goal;
        goal = nStb + n;
        i = 0;
        sel = s;
        cycDef.writeNotRead = wr;
        extWait <= ew;
        seqQ.delete();
        seqDw.delete();
        trkQ.delete();
        trkDw.delete();
        {naSeen, doneSeen, cmdSeen, dirOn} = 4'h0;
        req <= 1'b1;
        while (nStb < goal && i < 300) begin
            @(negedge clk);
            i++;
        end
        req <= 1'b0;
        while (!(mBusy === 1'b0 && localStateBits === LS_AWAIT) && i < 600)
        begin
            @(negedge clk);
            if (flip && localStateBits === LS_PCMD_ON) cycDef.writeNotRead = ~wr;
            i++;
        end
        repeat (4) @(negedge clk);
        chk(i < 600, "cycle hung");
    endtask

    task automatic t_one_wait();
        run_cycle(3'h5, 1'b0, 4'h0, 1, 1'b0);
        chk_seq(seqQ, '{LS_AWAIT, LS_SAMPLE, LS_ONE_WAIT, LS_RELEASE,
            LS_AWAIT}, "one-wait path");
        chk_seq(trkQ, '{BUS_QUIET, BUS_BUSY, BUS_QUIET}, "tracker");
        chk(naSeen && doneSeen && cmdSeen, "one-wait outputs");
        chk(cmdOn === 5'h0F, "memory read strobe");
        $display("one-wait test done");
    endtask

    task automatic t_periph(input logic wr);
        cycDef = wr ? 3'h4 : 3'h0;
        run_cycle(3'h6, wr, 4'h0, 1, wr);
        chk(cmdOn === (wr ? 5'h17 : 5'h1E), "strobe decode");
        chk_seq(seqQ, '{LS_AWAIT, LS_SAMPLE, LS_PAUSE, LS_PCMD_ON, LS_PCMD_OFF,
            LS_RELEASE, LS_AWAIT}, "peripheral path");
        chk(seqDw.size() > 2 && seqDw[2] == 1, "pause length");
        chk(onDly === (wr ? DLY_3 : DLY_2), "reload");
        chk(naSeen && doneSeen, "peripheral request");
        if (wr)
            chk(dirOn && !xcvrDirection, "direction copy");
        $display("peripheral test done");
    endtask

    task automatic t_foreign(input lbcc_sel_s s, input logic [3:0] ew);
        cycDef = (ew == 4'h0) ? 3'h2 : 3'h4;
        run_cycle(s, 1'b0, ew, 1, 1'b0);
        chk_seq(seqQ, '{LS_AWAIT, LS_SAMPLE, LS_FOREIGN, LS_AWAIT},
            "foreign path");
        chk(!naSeen, "no request");
        if (ew == 4'h0) begin
            chk(cmdSeen && doneSeen, "zero-wait strobes");
            chk(cmdOn === 5'h1B, "port read strobe");
        end
        $display("foreign test done");
    endtask

    task automatic t_overlap();
        run_cycle(3'h7, 1'b0, 4'h2, 2, 1'b0);
        chk_seq(seqQ, '{LS_AWAIT, LS_SAMPLE, LS_FOREIGN, LS_SAMPLE, LS_FOREIGN,
            LS_AWAIT}, "piped path");
        chk_seq(trkQ, '{BUS_QUIET, BUS_BUSY, BUS_OVERLAP, BUS_BUSY,
            BUS_QUIET}, "piped tracker");
        chk(trkDw.size() > 2 && trkDw[2] == 2, "overlap length");
        $display("overlap test done");
    endtask

    task automatic t_freeze();
        clkEn = 1'b0;
        run_cycle(3'h7, 1'b0, 4'h1, 1, 1'b0);
        chk(seqQ.size() == 1 && trkQ.size() == 1, "frozen moved");
        clkEn = 1'b1;
        $display("freeze test done");
    endtask

    task automatic t_abort();
        int i;
        sel = 3'h6;
        req <= 1'b1;
        for (i = 0; i < 100 && localStateBits !== LS_PCMD_ON; i++)
            @(negedge clk);
        reset_check(2);
        sel = 3'h7;
        $display("abort test done");
    endtask

    // Verdict and end of run
    task automatic finishTest();
        $display("comparisons %0d, mismatches %0d", cmpCount, nErrors);
        if (nErrors == 0 && cmpCount > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        reset_check(8);
        t_one_wait();
        t_periph(1'b0);
        t_periph(1'b1);
        t_foreign(3'h7, 4'h2);
        t_foreign(3'h3, 4'h0);
        t_overlap();
        t_freeze();
        t_abort();
        finishTest();
    end

    // Watchdog against a hang
    initial begin
        #(LBCC_CLK_PERIOD_NS * 20000);
        nErrors++;
        $display("[FAIL] %0t ns: watchdog expired", $time);
        finishTest();
    end
endmodule // lbcc_ctrl_test

`default_nettype wire
